// ### gap_counter_regs.svh
`ifndef GAP_COUNTER_REGS_SVH
`define GAP_COUNTER_REGS_SVH

// Counter and data widths
`define CNT_W 32
// Reset value of the running position count
`define CNT_RST 32'h00000000
// Decode mode encodings on mode_i
`define MODE_X1 3'h0
`define MODE_X2 3'h1
`define MODE_X4 3'h2
`define MODE_TWO_PULSE 3'h3
`define MODE_SEP_SINGLE 3'h4
`define MODE_SEP_IMPLICIT 3'h5
`define MODE_SEP_SAMPLED 3'h6
// Bit positions inside the synchronised input vector
`define IN_A 0
`define IN_B 1
`define IN_Z 2
`define IN_START 3
`define IN_STOP 4
`define IN_SAMPLE 5
`define IN_TBASE 6
`define IN_N 7

`endif

// ### gap_counter_pkg.sv
package gap_counter_pkg;

	// Measurement phase of the block
	typedef enum logic [1:0] {
		idle_type_st,
		run_st,
		count_st,
		hold_st
	} phase_type;

	// Result pushed toward the stream consumer
	typedef struct packed {
		logic [31:0] value;
		logic overrun;
	} result_type;

	// Whole state of the counter block
	typedef struct packed {
		logic [6:0] sync1;
		logic [6:0] sync2;
		logic [6:0] prev;
		phase_type phase;
		logic [31:0] count;
		logic [31:0] gap;
		logic gap_done;
		logic pair_seen;
		logic out_valid;
		result_type out;
		logic overrun;
	} state_type;

endpackage

// ### encoder_and_edge_gap_counter.sv
`timescale 1ns/100ps
`include "gap_counter_regs.svh"

module encoder_and_edge_gap_counter (
	// Clock and reset
	input wire logic core_clk_i,
	input wire logic rst_i,
	// Encoder and trigger pins
	input wire logic phase_a_i,
	input wire logic phase_b_i,
	input wire logic index_i,
	input wire logic start_i,
	input wire logic stop_i,
	input wire logic sample_i,
	input wire logic timebase_i,
	// Configuration
	input wire logic arm_i,
	input wire logic [2:0] mode_i,
	input wire logic [1:0] reload_phase_i,
	input wire logic index_en_i,
	input wire logic [31:0] reload_value_i,
	input wire logic sample_fall_i,
	input wire logic start_fall_i,
	input wire logic stop_fall_i,
	input wire logic tbase_fall_i,
	// Result stream and position readback
	output logic result_valid_o,
	input wire logic result_ready_i,
	output gap_counter_pkg::result_type result_o,
	output logic [31:0] position_o,
	output logic overrun_o,
	output logic armed_o
);

	gap_counter_pkg::state_type st;
	gap_counter_pkg::state_type next_st;
	logic [6:0] raw;
	logic [6:0] rise;
	logic [6:0] fall;
	logic a_lv;
	logic b_lv;
	logic step_up;
	logic step_dn;
	logic start_ev;
	logic stop_ev;
	logic sample_ev;
	logic tb_ev;
	logic in_phase;
	logic sep_mode;
	logic accepted;

	assign raw = {timebase_i, sample_i, stop_i, start_i, index_i,
		phase_b_i, phase_a_i};

	// Edge detection on the second synchroniser stage only
	assign rise = st.sync2 & ~st.prev;
	assign fall = ~st.sync2 & st.prev;
	assign a_lv = st.sync2[`IN_A];
	assign b_lv = st.sync2[`IN_B];
	assign start_ev = start_fall_i ? fall[`IN_START] : rise[`IN_START];
	assign stop_ev = stop_fall_i ? fall[`IN_STOP] : rise[`IN_STOP];
	assign sample_ev = sample_fall_i ? fall[`IN_SAMPLE] : rise[`IN_SAMPLE];
	assign tb_ev = tbase_fall_i ? fall[`IN_TBASE] : rise[`IN_TBASE];
	assign sep_mode = mode_i[2];
	assign accepted = st.out_valid & result_ready_i;
	// Reload phase code is {A,B} levels; 0 means both low
	assign in_phase = ({a_lv, b_lv} == reload_phase_i);

	// Step decoding; quadrature direction from the level of the other phase, two-pulse from which pin rises
	always_comb
	begin
		step_up = 1'b0;
		step_dn = 1'b0;
		case (mode_i)
			`MODE_X1:
			begin
				// A rising with B low means A leads
				step_up = rise[`IN_A] & ~b_lv;
				step_dn = fall[`IN_A] & ~b_lv;
			end
			`MODE_X2:
			begin
				step_up = (rise[`IN_A] & ~b_lv) | (fall[`IN_A] & b_lv);
				step_dn = (fall[`IN_A] & ~b_lv) | (rise[`IN_A] & b_lv);
			end
			`MODE_X4:
			begin
				step_up = (rise[`IN_A] & ~b_lv) | (fall[`IN_A] & b_lv) |
					(rise[`IN_B] & a_lv) | (fall[`IN_B] & ~a_lv);
				step_dn = (fall[`IN_A] & ~b_lv) | (rise[`IN_A] & b_lv) |
					(fall[`IN_B] & a_lv) | (rise[`IN_B] & ~a_lv);
			end
			`MODE_TWO_PULSE:
			begin
				step_up = rise[`IN_A];
				step_dn = rise[`IN_B];
			end
			default:
			begin
				step_up = 1'b0;
				step_dn = 1'b0;
			end
		endcase
	end

	// Next-state logic for the whole block
	always_comb
	begin
		next_st = st;
		next_st.sync1 = raw;
		next_st.sync2 = st.sync1;
		next_st.prev = st.sync2;
		// Output handshake: valid drops once the consumer takes it
		if (accepted)
			next_st.out_valid = 1'b0;
		// Leaving arm returns the phase to idle and clears gap_done and pair_seen; count and result are kept
		if (!arm_i)
		begin
			next_st.phase = gap_counter_pkg::idle_type_st;
			next_st.gap_done = 1'b0;
			next_st.pair_seen = 1'b0;
		end
		else
		begin
			case (st.phase)
				gap_counter_pkg::idle_type_st:
				begin
					// Arm event: cumulative count begins from zero
					next_st.phase = gap_counter_pkg::run_st;
					next_st.count = `CNT_RST;
					next_st.gap = `CNT_RST;
					next_st.overrun = 1'b0;
				end
				gap_counter_pkg::run_st:
				begin
					if (!sep_mode)
					begin
						// Step first; an index reload in the same cycle wins
						if (step_up)
							next_st.count = st.count + 32'h00000001;
						else if (step_dn)
							next_st.count = st.count - 32'h00000001;
						// Reload lands one cycle after the phase is seen
						if (index_en_i && st.sync2[`IN_Z] && in_phase &&
							mode_i != `MODE_TWO_PULSE)
							next_st.count = reload_value_i;
						// Capture without clearing the running count
						if (sample_ev && !st.out_valid)
						begin
							next_st.out_valid = 1'b1;
							next_st.out.value = next_st.count;
							next_st.out.overrun = 1'b0;
						end
					end
					// A held interval blocks a new start until it is sampled
					else if (start_ev && !st.gap_done)
					begin
						next_st.phase = gap_counter_pkg::count_st;
						next_st.gap = `CNT_RST;
					end
				end
				gap_counter_pkg::count_st:
				begin
					// Start edges are ignored here by construction
					if (tb_ev)
						next_st.gap = st.gap + 32'h00000001;
					if (stop_ev)
					begin
						if (mode_i == `MODE_SEP_SAMPLED)
						begin
							// Hold the interval until the next sample edge
							next_st.gap_done = 1'b1;
							next_st.pair_seen = 1'b1;
							next_st.phase = gap_counter_pkg::run_st;
						end
						else
						begin
							next_st.out_valid = 1'b1;
							next_st.out.value = next_st.gap;
							next_st.out.overrun = 1'b0;
							next_st.phase = (mode_i == `MODE_SEP_SINGLE) ?
								gap_counter_pkg::hold_st :
								gap_counter_pkg::run_st;
						end
					end
				end
				gap_counter_pkg::hold_st:
				begin
					// Single shot stays in hold, even after the result is taken, until arm drops
					if (accepted)
						next_st.phase = gap_counter_pkg::hold_st;
				end
				default:
					next_st.phase = gap_counter_pkg::idle_type_st;
			endcase
			// Sample-clocked interval hand-off and overrun check
			if (mode_i == `MODE_SEP_SAMPLED && sample_ev)
			begin
				next_st.out_valid = 1'b1;
				next_st.out.value = next_st.gap;
				next_st.out.overrun = ~next_st.pair_seen;
				if (!next_st.pair_seen)
					next_st.overrun = 1'b1;
				next_st.pair_seen = 1'b0;
				next_st.gap_done = 1'b0;
			end
		end
	end

	// State register; pins enter only through sync1
	always_ff @(posedge core_clk_i or posedge rst_i)
	begin
		if (rst_i)
		begin
			st.sync1 <= 7'h00;
			st.sync2 <= 7'h00;
			st.prev <= 7'h00;
			st.phase <= gap_counter_pkg::idle_type_st;
			st.count <= `CNT_RST;
			st.gap <= `CNT_RST;
			st.gap_done <= 1'b0;
			st.pair_seen <= 1'b0;
			st.out_valid <= 1'b0;
			st.out <= '0;
			st.overrun <= 1'b0;
		end
		else
			st <= next_st;
	end

	// Outputs
	assign result_valid_o = st.out_valid;
	assign result_o = st.out;
	assign position_o = st.count;
	assign overrun_o = st.overrun;
	assign armed_o = (st.phase != gap_counter_pkg::idle_type_st);

	// ----------------------------------------
	// Checks
	// ----------------------------------------
	a_no_count_unarmed: assert property (@(posedge core_clk_i) disable iff (rst_i)
		(st.phase == gap_counter_pkg::idle_type_st) |=> $stable(st.count) ||
		st.count == `CNT_RST) else $error("count moved while unarmed");
	a_x1_step_up: assert property (@(posedge core_clk_i) disable iff (rst_i)
		(arm_i && st.phase == gap_counter_pkg::run_st && mode_i == `MODE_X1 &&
		rise[`IN_A] && !b_lv && !(index_en_i && st.sync2[`IN_Z] && in_phase))
		|=> st.count == $past(st.count) + 32'h00000001)
		else $error("x1 up step missed");
	a_two_pulse_dn: assert property (@(posedge core_clk_i) disable iff (rst_i)
		(arm_i && st.phase == gap_counter_pkg::run_st &&
		mode_i == `MODE_TWO_PULSE && rise[`IN_B] && !rise[`IN_A])
		|=> st.count == $past(st.count) - 32'h00000001)
		else $error("two pulse down missed");
	a_reload_value: assert property (@(posedge core_clk_i) disable iff (rst_i)
		(arm_i && st.phase == gap_counter_pkg::run_st && !sep_mode &&
		mode_i != `MODE_TWO_PULSE && index_en_i && st.sync2[`IN_Z] &&
		in_phase) |=> st.count == $past(reload_value_i))
		else $error("reload not applied");
	a_capture_value: assert property (@(posedge core_clk_i) disable iff (rst_i)
		(arm_i && st.phase == gap_counter_pkg::run_st && !sep_mode &&
		sample_ev && !st.out_valid) |=> result_valid_o &&
		result_o.value == st.count) else $error("capture wrong");
	a_stop_stores: assert property (@(posedge core_clk_i) disable iff (rst_i)
		(arm_i && st.phase == gap_counter_pkg::count_st && stop_ev &&
		mode_i != `MODE_SEP_SAMPLED) |=> result_valid_o)
		else $error("stop did not store");
	a_single_holds: assert property (@(posedge core_clk_i) disable iff (rst_i)
		(arm_i && st.phase == gap_counter_pkg::hold_st) |=>
		st.phase == gap_counter_pkg::hold_st || !$past(arm_i) || !arm_i)
		else $error("single shot left hold");
	a_overrun_flag: assert property (@(posedge core_clk_i) disable iff (rst_i)
		(arm_i && st.phase != gap_counter_pkg::idle_type_st &&
		mode_i == `MODE_SEP_SAMPLED && sample_ev && !st.pair_seen &&
		!(st.phase == gap_counter_pkg::count_st && stop_ev))
		|=> overrun_o) else $error("overrun not flagged");
	a_x1_step_dn: assert property (
		@(posedge core_clk_i) disable iff (rst_i)
		(arm_i && st.phase == gap_counter_pkg::run_st &&
		mode_i == `MODE_X1 && fall[`IN_A] && !b_lv &&
		!(index_en_i && st.sync2[`IN_Z] && in_phase))
		|=> st.count == $past(st.count) - 32'h00000001)
		else $error("x1 down step missed");
	a_x2_fall_up: assert property (
		@(posedge core_clk_i) disable iff (rst_i)
		(arm_i && st.phase == gap_counter_pkg::run_st &&
		mode_i == `MODE_X2 && fall[`IN_A] && b_lv &&
		!(index_en_i && st.sync2[`IN_Z] && in_phase))
		|=> st.count == $past(st.count) + 32'h00000001)
		else $error("x2 up step missed");
	a_x4_b_rise: assert property (
		@(posedge core_clk_i) disable iff (rst_i)
		(arm_i && st.phase == gap_counter_pkg::run_st &&
		mode_i == `MODE_X4 && rise[`IN_B] && a_lv && !rise[`IN_A] &&
		!fall[`IN_A] && !(index_en_i && st.sync2[`IN_Z] && in_phase))
		|=> st.count == $past(st.count) + 32'h00000001)
		else $error("x4 b edge step missed");
	a_two_pulse_up: assert property (
		@(posedge core_clk_i) disable iff (rst_i)
		(arm_i && st.phase == gap_counter_pkg::run_st &&
		mode_i == `MODE_TWO_PULSE && rise[`IN_A] &&
		!rise[`IN_B])
		|=> st.count == $past(st.count) + 32'h00000001)
		else $error("two pulse up missed");
	a_sample_keeps_count: assert property (
		@(posedge core_clk_i) disable iff (rst_i)
		(arm_i && st.phase == gap_counter_pkg::run_st && !sep_mode &&
		sample_ev && !step_up && !step_dn &&
		!(index_en_i && st.sync2[`IN_Z] && in_phase))
		|=> $stable(st.count))
		else $error("sample edge moved the count");
	a_start_ignored: assert property (
		@(posedge core_clk_i) disable iff (rst_i)
		(arm_i && st.phase == gap_counter_pkg::count_st &&
		start_ev && !stop_ev &&
		sep_mode)
		|=> st.phase == gap_counter_pkg::count_st)
		else $error("start edge left counting");
	a_gap_counts: assert property (
		@(posedge core_clk_i) disable iff (rst_i)
		(arm_i && st.phase == gap_counter_pkg::count_st &&
		tb_ev && !stop_ev &&
		sep_mode)
		|=> st.gap == $past(st.gap) + 32'h00000001)
		else $error("timebase edge not counted");
	a_sample_hands_gap: assert property (
		@(posedge core_clk_i) disable iff (rst_i)
		(arm_i && st.phase != gap_counter_pkg::idle_type_st &&
		mode_i == `MODE_SEP_SAMPLED &&
		sample_ev)
		|=> result_valid_o)
		else $error("sampled interval not handed over");

endmodule

// ### encoder_model.sv
`timescale 1ns/100ps
// ----------------------------------------
// Encoder pin model
// ----------------------------------------
module encoder_model (
	// Clock
	input wire logic core_clk_i,
	// Encoder pins toward the counter
	output logic phase_a_o,
	output logic phase_b_o
);
	logic [1:0] quad = 2'h0;

	// Gray order 00,10,11,01 forward, so A leads B when moving up
	assign phase_a_o = quad[1];
	assign phase_b_o = quad[0];

	// One quarter cycle; gap sets how slowly the shaft turns
	task automatic step(input logic fwd, input int gap);
		@(posedge core_clk_i);
		quad <= fwd ? {~quad[0], quad[1]} : {quad[0], ~quad[1]};
		repeat (gap) @(posedge core_clk_i);
	endtask

	// Lone rising pulse on A or B, as a two-pulse encoder gives
	task automatic pulse(input logic on_b);
		@(posedge core_clk_i);
		quad <= on_b ? 2'h1 : 2'h2;
		repeat (6) @(posedge core_clk_i);
		quad <= 2'h0;
		repeat (6) @(posedge core_clk_i);
	endtask
endmodule

// ### tb_encoder_and_edge_gap_counter.sv
`timescale 1ns/100ps
// ----------------------------------------
// Self-checking bench for the counter
// ----------------------------------------
module tb_encoder_and_edge_gap_counter;
	logic core_clk_i = 1'b0;
	logic rst_i = 1'b1;
	logic a, b, idx, arm, en, sf, pf, mf, rdy, vld, ovr;
	logic [3:0] pins, idle;
	logic [2:0] mode;
	logic [1:0] rph;
	logic [31:0] rval, pos, seed, r;
	gap_counter_pkg::result_type res, e;
	gap_counter_pkg::result_type q[$];
	int err_count = 0;
	int tests_run = 0;
	int c;

	always #50 core_clk_i = ~core_clk_i;

	encoder_model enc (
		.core_clk_i(core_clk_i),
		.phase_a_o(a),
		.phase_b_o(b)
	);

	// Pins: 0 start, 1 stop, 2 sample, 3 timebase
	encoder_and_edge_gap_counter DUT (
		.core_clk_i(core_clk_i),
		.rst_i(rst_i),
		.phase_a_i(a),
		.phase_b_i(b),
		.index_i(idx),
		.start_i(pins[0]),
		.stop_i(pins[1]),
		.sample_i(pins[2]),
		.timebase_i(pins[3]),
		.arm_i(arm),
		.mode_i(mode),
		.reload_phase_i(rph),
		.index_en_i(en),
		.reload_value_i(rval),
		.sample_fall_i(mf),
		.start_fall_i(sf),
		.stop_fall_i(pf),
		.tbase_fall_i(1'b0),
		.result_valid_o(vld),
		.result_ready_i(rdy),
		.result_o(res),
		.position_o(pos),
		.overrun_o(ovr),
		.armed_o()
	);

	task automatic cyc(input int n);
		repeat (n) @(posedge core_clk_i);
	endtask

	// Compare a settled port value; chk_pos samples at the falling edge, the result monitor at the rising edge
	task automatic chk(input string n, input logic [31:0] x, logic [31:0] g);
		tests_run++;
		if (g !== x)
		begin
			err_count++;
			$display("mismatch %s exp %h got %h", n, x, g);
		end
	endtask

	task automatic chk_pos(input logic [31:0] x);
		@(negedge core_clk_i);
		chk("position", x, pos);
	endtask

	// Active edge first, long enough for the synchroniser
	task automatic pulse(input int k);
		cyc(1);
		pins[k] <= ~idle[k];
		cyc(6);
		pins[k] <= idle[k];
		cyc(6);
	endtask

	task automatic expect_res(input logic [31:0] v);
		q.push_back({v, 1'b0});
	endtask

	// Mode only changes while unarmed, so drop arm first
	task automatic do_arm(input logic [2:0] m);
		cyc(1);
		arm <= 1'b0;
		mode <= m;
		cyc(2);
		arm <= 1'b1;
		cyc(2);
	endtask

	// Interval of n timebase edges, a stray start edge in mid-count
	task automatic gap(input int n);
		pulse(0);
		for (int i = 0; i < n; i++)
		begin
			pulse(3);
			if (i == 0)
				pulse(0);
		end
		pulse(1);
	endtask

	task automatic steps(input logic fwd, input int n);
		for (int i = 0; i < n; i++)
			enc.step(fwd, 5);
	endtask

	task automatic drain;
		for (int i = 0; i < 300 && q.size() != 0; i++)
			cyc(1);
		if (q.size() != 0)
		begin
			err_count++;
			$display("mismatch stream exp %0d results got none", q.size());
			report_and_stop;
		end
	endtask

	task automatic report_and_stop;
		$display("checks %0d mismatches %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask

	// Take the oldest note when a result is handed over; none is an error
	always @(posedge core_clk_i)
	begin
		if (!rst_i && vld === 1'b1 && rdy === 1'b1)
		begin
			e = (q.size() != 0) ? q.pop_front() : 'x;
			chk("result", {e.value}, {res.value});
			chk("result overrun", {31'h0, e.overrun}, {31'h0, res.overrun});
		end
	end

	initial
	begin
		seed = 32'h13ED260C;
		r = $random(seed);
		rval = $random(seed);
		{sf, pf, mf} = r[2:0];
		rph = r[4:3];
		idle = {1'b0, mf, pf, sf};
		pins = idle;
		{arm, idx, en, rdy, mode} = {4'b0011, 3'h0};
		cyc(2);
		rst_i <= 1'b0;
		steps(1'b1, 4);
		chk_pos(32'h0);
		// Each quadrature mode (x1, x2, x4): count up, capture twice, count back down
		for (int m = 0; m < 3; m++)
		begin
			c = r[5 + m] + 1;
			do_arm(m[2:0]);
			steps(1'b1, 4 * c);
			chk_pos(c << m);
			expect_res(c << m);
			pulse(2);
			steps(1'b1, 4);
			expect_res((c + 1) << m);
			pulse(2);
			steps(1'b0, 4 * (c + 1));
			chk_pos(32'h0);
		end
		do_arm(3'h3);
		repeat (3) enc.pulse(1'b0);
		enc.pulse(1'b1);
		chk_pos(32'h2);
		// Index high while stepping into the chosen phase
		do_arm(3'h2);
		idx <= 1'b1;
		do
			enc.step(1'b1, 5);
		while ({a, b} !== rph);
		idx <= 1'b0;
		chk_pos(rval);
		enc.step(1'b1, 5);
		chk_pos(rval + 32'h1);
		// Separation modes: single holds after one result
		do_arm(3'h4);
		expect_res(32'h5);
		gap(5);
		gap(3);
		do_arm(3'h5);
		expect_res(32'h4);
		gap(4);
		expect_res(32'h7);
		gap(7);
		do_arm(3'h6);
		gap(6);
		expect_res(32'h6);
		pulse(2);
		drain;
		rdy <= 1'b0;
		pulse(2);
		@(negedge core_clk_i);
		chk("overrun", 32'h1, {31'h0, ovr});
		report_and_stop;
	end
endmodule
